// [src/rdc_core.sv]
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rdc_core #(
  parameter int SLOT_CYCLES = rdc_pkg::SLOT_CYCLES,
  parameter int CFG_SETTLE_CYCLES = rdc_pkg::CFG_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire rdc_pkg::rdc_ahb_req_t ahb_req,
  output rdc_pkg::rdc_ahb_rsp_t ahb_rsp,
  // analog indications and static selects
  input wire rdc_pkg::rdc_sense_t sense,
  // channel on/off drive
  output logic [7:0] red_channel_outputs,
  output logic [7:0] green_channel_outputs,
  output logic [7:0] blue_channel_outputs,
  // sink mode and current level
  output rdc_pkg::rdc_sink_t sink
);

  localparam int DIV_W = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;
  localparam int CFG_W = $clog2(CFG_SETTLE_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOT_CYCLES - 1);
  localparam logic [CFG_W-1:0] CFG_LAST = CFG_W'(CFG_SETTLE_CYCLES);
  localparam logic [4:0] IDX_RED = rdc_pkg::ADDR_RED_CUR[6:2];
  localparam logic [4:0] IDX_GRN = rdc_pkg::ADDR_GRN_CUR[6:2];
  localparam logic [4:0] IDX_BLU = rdc_pkg::ADDR_BLU_CUR[6:2];
  localparam logic [4:0] IDX_DUTY = rdc_pkg::ADDR_DUTY_BASE[6:2];
  localparam logic [4:0] IDX_STATUS = rdc_pkg::ADDR_STATUS[6:2];
  localparam logic [4:0] NUM_CH_5 = 5'(rdc_pkg::NUM_CH);

  typedef struct packed {
    logic [2:0][4:0] cur;
    logic [23:0][7:0] duty;
    logic [7:0] slot;
    logic [DIV_W-1:0] div;
    logic dph_wr;
    logic [4:0] dph_idx;
    logic dph_map;
    logic [31:0] rdata;
    logic supply_q;
    logic [CFG_W-1:0] cfg_cnt;
    logic cfg_done;
    logic [1:0] otype;
    logic all_ref;
    logic [23:0] on;
    logic [23:0] cc;
    logic [2:0][4:0] lvl;
  } rdc_core_st_t;

  localparam rdc_core_st_t ST_RST = '{
    cur: {3{rdc_pkg::CUR_RST}},
    duty: {24{rdc_pkg::DUTY_RST}},
    slot: 8'h00,
    div: '0,
    dph_wr: 1'b0,
    dph_idx: 5'h00,
    dph_map: 1'b0,
    rdata: 32'h0000_0000,
    supply_q: 1'b0,
    cfg_cnt: '0,
    cfg_done: 1'b0,
    otype: rdc_pkg::OTYPE_LOW,
    all_ref: 1'b0,
    on: 24'h00_0000,
    cc: 24'h00_0000,
    lvl: {3{rdc_pkg::CUR_RST}}
  };

  rdc_core_st_t s_r;
  rdc_core_st_t s_nxt;
  rdc_pkg::rdc_sense_t sn;

  // refuse settings the logic cannot serve
  if (SLOT_CYCLES < 1)
  begin : g_bad_slot
    $error("rdc_core: SLOT_CYCLES must be at least 1");
  end
  if (CFG_SETTLE_CYCLES < 4)
  begin : g_bad_settle
    $error("rdc_core: CFG_SETTLE_CYCLES must cover the input chain");
  end
  if (rdc_pkg::NUM_CH != rdc_pkg::NUM_GROUPS * rdc_pkg::CH_PER_GROUP)
  begin : g_bad_groups
    $error("rdc_core: channels must fill the color groups");
  end
  if (rdc_pkg::CC_SPLIT > rdc_pkg::CH_PER_GROUP)
  begin : g_bad_split
    $error("rdc_core: constant-current split exceeds the group");
  end
  if (rdc_pkg::DUTY_W != rdc_pkg::SLOT_W)
  begin : g_bad_width
    $error("rdc_core: duty and slot widths must match");
  end
  if (int'(IDX_DUTY) + rdc_pkg::NUM_CH > int'(IDX_STATUS))
  begin : g_bad_map
    $error("rdc_core: duty registers overlap the status register");
  end

  // all analog indications pass the three-stage filter
  rdc_sync #(
    .W($bits(rdc_pkg::rdc_sense_t))
  ) u_sense_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(sense),
    .q(sn)
  );

  logic addr_ph;
  logic addr_map;
  logic [4:0] widx;
  logic clr;
  logic run;
  logic [4:0] didx;
  logic [4:0] rdidx;

  // address phase decode
  assign addr_ph = ahb_req.hsel && ahb_req.hready
                   && ahb_req.htrans[rdc_pkg::HTRANS_ACTIVE_BIT];
  assign addr_map = (ahb_req.haddr[31:rdc_pkg::MAP_TOP_BIT] == '0);
  assign widx = ahb_req.haddr[6:2];

  // register clear on a supply rise once the filter has settled, or while
  // external reset is high; the filter's own start is not a rise
  assign clr = (sn.supply_ok && !s_r.supply_q && s_r.cfg_done)
               || sn.ext_reset;

  // outputs may run only when no protection holds them off
  assign run = s_r.cfg_done && sn.supply_ok && !sn.uvlo
               && !sn.overtemp && !sn.ext_reset;

  assign didx = s_r.dph_idx - IDX_DUTY;
  assign rdidx = widx - IDX_DUTY;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.supply_q = sn.supply_ok;

    // data phase write, one whole word, low bits kept
    if (s_r.dph_wr && s_r.dph_map && !clr)
    begin
      if (s_r.dph_idx == IDX_RED)
      begin
        s_nxt.cur[0] = ahb_req.hwdata[4:0];
      end
      else if (s_r.dph_idx == IDX_GRN)
      begin
        s_nxt.cur[1] = ahb_req.hwdata[4:0];
      end
      else if (s_r.dph_idx == IDX_BLU)
      begin
        s_nxt.cur[2] = ahb_req.hwdata[4:0];
      end
      else if (s_r.dph_idx >= IDX_DUTY && didx < NUM_CH_5)
      begin
        s_nxt.duty[didx] = ahb_req.hwdata[7:0];
      end
    end

    // clearing wins over any write in the same cycle
    if (clr)
    begin
      s_nxt.cur = {3{rdc_pkg::CUR_RST}};
      s_nxt.duty = {24{rdc_pkg::DUTY_RST}};
    end

    // address phase capture; read data forwards a write in flight
    s_nxt.dph_wr = 1'b0;
    if (addr_ph)
    begin
      s_nxt.dph_wr = ahb_req.hwrite;
      s_nxt.dph_idx = widx;
      s_nxt.dph_map = addr_map;
      s_nxt.rdata = 32'h0000_0000;
      if (!ahb_req.hwrite && addr_map)
      begin
        if (widx == IDX_RED)
        begin
          s_nxt.rdata[4:0] = s_nxt.cur[0];
        end
        else if (widx == IDX_GRN)
        begin
          s_nxt.rdata[4:0] = s_nxt.cur[1];
        end
        else if (widx == IDX_BLU)
        begin
          s_nxt.rdata[4:0] = s_nxt.cur[2];
        end
        else if (widx >= IDX_DUTY && rdidx < NUM_CH_5)
        begin
          s_nxt.rdata[7:0] = s_nxt.duty[rdidx];
        end
        else if (widx == IDX_STATUS)
        begin
          s_nxt.rdata[rdc_pkg::ST_SUPPLY_OK] = sn.supply_ok;
          s_nxt.rdata[rdc_pkg::ST_UVLO] = sn.uvlo;
          s_nxt.rdata[rdc_pkg::ST_OVERTEMP] = sn.overtemp;
          s_nxt.rdata[rdc_pkg::ST_EXT_RESET] = sn.ext_reset;
          s_nxt.rdata[rdc_pkg::ST_OTYPE_LO +: 2] = s_r.otype;
          s_nxt.rdata[rdc_pkg::ST_ALL_REF] = s_r.all_ref;
          s_nxt.rdata[rdc_pkg::ST_CFG_DONE] = s_r.cfg_done;
          s_nxt.rdata[rdc_pkg::ST_SLOT_LO +: 8] = s_r.slot;
        end
      end
    end

    // static selects taken once the input chain has settled
    if (!s_r.cfg_done)
    begin
      if (s_r.cfg_cnt == CFG_LAST)
      begin
        s_nxt.cfg_done = 1'b1;
        s_nxt.otype = sn.output_type_select;
        s_nxt.all_ref = sn.all_ref;
      end
      else
      begin
        s_nxt.cfg_cnt = s_r.cfg_cnt + CFG_W'(1);
      end
    end

    // slot divider and free-running slot counter, fixed window
    if (s_r.div == DIV_LAST)
    begin
      s_nxt.div = '0;
      s_nxt.slot = s_r.slot + 8'h01;
    end
    else
    begin
      s_nxt.div = s_r.div + DIV_W'(1);
    end

    // per-channel on while slot below duty; code 255 still ends off
    for (int c = 0; c < rdc_pkg::NUM_CH; c++)
    begin
      s_nxt.on[c] = run && (s_r.slot < s_r.duty[c]);
    end

    // sink mode per channel, open drain until the select is captured
    for (int g = 0; g < rdc_pkg::NUM_GROUPS; g++)
    begin
      for (int k = 0; k < rdc_pkg::CH_PER_GROUP; k++)
      begin
        if (!s_r.cfg_done)
        begin
          s_nxt.cc[g * rdc_pkg::CH_PER_GROUP + k] = 1'b0;
        end
        else if (s_r.otype == rdc_pkg::OTYPE_LOW)
        begin
          s_nxt.cc[g * rdc_pkg::CH_PER_GROUP + k] = 1'b1;
        end
        else if (s_r.otype == rdc_pkg::OTYPE_MID)
        begin
          s_nxt.cc[g * rdc_pkg::CH_PER_GROUP + k] =
            (k < rdc_pkg::CC_SPLIT);
        end
        else
        begin
          s_nxt.cc[g * rdc_pkg::CH_PER_GROUP + k] = 1'b0;
        end
      end
      // group level: codes apply, or full with three resistors
      if (s_r.all_ref)
      begin
        s_nxt.lvl[g] = rdc_pkg::CUR_FULL;
      end
      else
      begin
        s_nxt.lvl[g] = s_r.cur[g];
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_r <= ST_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // bus answer: zero wait states, always okay
  always_comb
  begin
    ahb_rsp.hreadyout = 1'b1;
    ahb_rsp.hrdata = s_r.rdata;
    ahb_rsp.hresp = rdc_pkg::HRESP_OKAY;
  end

  // channel and sink outputs straight from state
  assign red_channel_outputs = s_r.on[7:0];
  assign green_channel_outputs = s_r.on[15:8];
  assign blue_channel_outputs = s_r.on[23:16];
  assign sink.const_current = s_r.cc;
  assign sink.group_level = s_r.lvl;

endmodule : rdc_core
`default_nettype wire

// [src/rdc_pkg.sv]
// Notes on behaviour
// - a rising system supply clears every duty and current code
// - while undervoltage lockout is flagged, all channel outputs stay off
// - 24 channels form red, green, blue groups of eight sharing one current
// - each group has a 5-bit current code, about 3 to 100 percent
// - each channel has an 8-bit duty code, steps of 1/256 of the window
// - duty zero keeps a channel off; no code turns it on all window
// - the cycle window length is fixed, independent of any code
// - output type low: all channels are constant-current sinks at group code
// - output type high: all channels open-drain, group code unused, duty kept
// - output type middle: channels 1-6 constant-current, 7-8 open-drain
// - only red reference resistor fitted: group current codes take effect
// - all three reference resistors fitted: every group runs at full current
// - the external reset input clears all codes while it is high
// - overtemperature forces all outputs off, unlatched, resuming when clear
// - red group current code sits in low five bits of address zero
package rdc_pkg;

  // channel organisation
  localparam int NUM_GROUPS = 3;
  localparam int CH_PER_GROUP = 8;
  localparam int NUM_CH = 24;
  localparam int CC_SPLIT = 6;
  localparam int CUR_W = 5;
  localparam int DUTY_W = 8;
  localparam int SLOT_W = 8;

  // register byte addresses
  localparam logic [31:0] ADDR_RED_CUR = 32'h0000_0000;
  localparam logic [31:0] ADDR_GRN_CUR = 32'h0000_0004;
  localparam logic [31:0] ADDR_BLU_CUR = 32'h0000_0008;
  localparam logic [31:0] ADDR_DUTY_BASE = 32'h0000_000c;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0070;
  localparam int MAP_TOP_BIT = 7;

  // reset values and the full current code
  localparam logic [4:0] CUR_RST = 5'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [4:0] CUR_FULL = 5'h1f;

  // status register fields
  localparam int ST_SUPPLY_OK = 0;
  localparam int ST_UVLO = 1;
  localparam int ST_OVERTEMP = 2;
  localparam int ST_EXT_RESET = 3;
  localparam int ST_OTYPE_LO = 4;
  localparam int ST_ALL_REF = 6;
  localparam int ST_CFG_DONE = 7;
  localparam int ST_SLOT_LO = 8;

  // decoded output type select codes
  localparam logic [1:0] OTYPE_LOW = 2'h0;
  localparam logic [1:0] OTYPE_MID = 2'h1;
  localparam logic [1:0] OTYPE_HIGH = 2'h2;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // timing
  localparam int CLK_FREQ_MHZ = 125;
  localparam int SLOT_TIME_NS = 32;
  localparam int SLOT_CYCLES = (SLOT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CFG_SETTLE_CYCLES = 4;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } rdc_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
  } rdc_ahb_rsp_t;

  // raw indications from the analog side
  typedef struct packed {
    logic supply_ok;
    logic uvlo;
    logic overtemp;
    logic ext_reset;
    logic [1:0] output_type_select;
    logic all_ref;
  } rdc_sense_t;

  // per-channel sink setup for the current dacs
  typedef struct packed {
    logic [23:0] const_current;
    logic [2:0][4:0] group_level;
  } rdc_sink_t;

endpackage : rdc_pkg

// [src/rdc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module rdc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } rdc_sync_st_t;

  rdc_sync_st_t s_r;
  rdc_sync_st_t s_nxt;

  // refuse an empty chain
  if (W < 1)
  begin : g_bad_width
    $error("rdc_sync: W must be at least 1");
  end

  // three-stage chain, level accepted once stages two and three agree
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (s_r.s2[i] == s_r.s3[i])
      begin
        s_nxt.q[i] = s_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule : rdc_sync
`default_nettype wire

// [verification/rdc_core_props.sv]
`timescale 1ns/1ps
`default_nettype none
module rdc_core_props #(
  parameter int SLOT_CYCLES = 4,
  parameter int CFG_SETTLE_CYCLES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus
  input wire rdc_pkg::rdc_ahb_req_t ahb_req,
  input wire rdc_pkg::rdc_ahb_rsp_t ahb_rsp,
  // indications
  input wire rdc_pkg::rdc_sense_t sense,
  // channel drive
  input wire logic [7:0] red_channel_outputs,
  input wire logic [7:0] green_channel_outputs,
  input wire logic [7:0] blue_channel_outputs,
  input wire rdc_pkg::rdc_sink_t sink
);
  logic [3:0] up_r;
  logic [15:0] on_r;
  logic ok;
  logic [23:0] outs;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // all channels as one word, settle flag
  assign outs = {blue_channel_outputs, green_channel_outputs,
    red_channel_outputs};
  assign ok = (up_r == 4'hf);
  // cycles since reset, run length of the last blue channel
  always_ff @(posedge clk)
  begin
    up_r <= sys_rst ? 4'h0 : (ok ? up_r : up_r + 4'h1);
    on_r <= (sys_rst || !blue_channel_outputs[7]) ? 16'h0 : on_r + 16'h1;
  end
  sequence lockout_held;
    sense.uvlo [*6];
  endsequence
  sequence heat_held;
    sense.overtemp [*6];
  endsequence
  rst_clear_a: assert property (disable iff (1'b0) sys_rst |=>
    outs == 24'h0 && sink == '0 && ahb_rsp.hrdata == 32'h0)
    else $error("outputs not clear after reset");
  uvlo_off_a: assert property (lockout_held |-> outs == 24'h0)
    else $error("channel on during lockout");
  heat_off_a: assert property (heat_held |-> outs == 24'h0)
    else $error("channel on during overtemperature");
  ext_off_a: assert property (sense.ext_reset [*6] |-> outs == 24'h0)
    else $error("channel on during external reset");
  full_cur_a: assert property (ok && sense.all_ref |->
    sink.group_level == {3{5'h1f}}) else $error("level not full");
  low_sink_a: assert property (ok && sense.output_type_select ==
    rdc_pkg::OTYPE_LOW |-> sink.const_current == 24'hff_ffff)
    else $error("low type not all constant current");
  mid_sink_a: assert property (ok && sense.output_type_select ==
    rdc_pkg::OTYPE_MID |-> sink.const_current == 24'h3f_3f3f)
    else $error("middle type split wrong");
  high_drain_a: assert property (ok && sense.output_type_select ==
    rdc_pkg::OTYPE_HIGH |-> sink.const_current == 24'h0)
    else $error("high type not open drain");
  never_full_a: assert property (on_r < 16'(256 * SLOT_CYCLES))
    else $error("channel on for a whole window");
  bus_okay_a: assert property (ahb_rsp.hreadyout && ahb_rsp.hresp ==
    rdc_pkg::HRESP_OKAY) else $error("bus answer not ready and okay");
endmodule : rdc_core_props
bind rdc_core rdc_core_props #(.SLOT_CYCLES(SLOT_CYCLES),
  .CFG_SETTLE_CYCLES(CFG_SETTLE_CYCLES)) rdc_core_props_i (.clk(clk),
  .sys_rst(sys_rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .sense(sense),
  .red_channel_outputs(red_channel_outputs),
  .green_channel_outputs(green_channel_outputs),
  .blue_channel_outputs(blue_channel_outputs), .sink(sink));
`default_nettype wire

// [verification/rdc_leds.sv]
`timescale 1ns/1ps
`default_nettype none
module rdc_leds (
  // clock and count clear
  input wire logic clk,
  input wire logic clear,
  // channel drive, bit n is channel n
  input wire logic [23:0] drive,
  // cycles each string was lit
  output logic [15:0] on_cnt [24]
);
  // strings light while their channel sinks
  always_ff @(posedge clk)
  begin
    for (int n = 0; n < 24; n++)
      on_cnt[n] <= clear ? 16'h0 : on_cnt[n] + 16'(drive[n]);
  end
endmodule : rdc_leds
`default_nettype wire

// [verification/rgb_led_dimming_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module rgb_led_dimming_control_bench;
  localparam int SC = 1;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clr = 1'b0;
  rdc_pkg::rdc_ahb_req_t rq = '0;
  rdc_pkg::rdc_ahb_rsp_t rs;
  rdc_pkg::rdc_sense_t sn = '0;
  logic [7:0] r_o, g_o, b_o;
  rdc_pkg::rdc_sink_t sk;
  logic [15:0] cnt [24];
  logic [31:0] q;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always @* rq.hready = rs.hreadyout;
  rdc_core #(.SLOT_CYCLES(SC)) rdc_core_i (.clk(clk), .sys_rst(sys_rst),
    .ahb_req(rq), .ahb_rsp(rs), .sense(sn), .red_channel_outputs(r_o),
    .green_channel_outputs(g_o), .blue_channel_outputs(b_o), .sink(sk));
  rdc_leds rdc_leds_i (.clk(clk), .clear(clr), .drive({b_o, g_o, r_o}),
    .on_cnt(cnt));
  // duty code used for each channel
  function automatic logic [7:0] dv(input int n);
    return n == 0 ? 8'h00 : n == 1 ? 8'h01 : n == 23 ? 8'hff : 8'(n * 11);
  endfunction : dv
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one single ahb transfer, address then data phase
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r);
    rq.hsel <= 1'b1;
    rq.haddr <= a;
    rq.htrans <= 2'h2;
    rq.hwrite <= w;
    rq.hsize <= 3'h2;
    do @(posedge clk); while (rs.hreadyout !== 1'b1);
    rq.htrans <= 2'h0;
    rq.hwdata <= d;
    do @(posedge clk); while (rs.hreadyout !== 1'b1);
    r = rs.hrdata;
  endtask : xfer
  task automatic rst_to(input logic [1:0] t, input logic ar);
    sys_rst <= 1'b1;
    sn <= '{supply_ok: 1'b1, output_type_select: t, all_ref: ar,
      default: 1'b0};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : rst_to
  task automatic load_duty();
    for (int n = 0; n < 24; n++)
      xfer(1'b1, rdc_pkg::ADDR_DUTY_BASE + 32'(4 * n), 32'(dv(n)), q);
    repeat (300) @(posedge clk);
  endtask : load_duty
  // lit time of every string over one window
  task automatic meas(input logic on);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (256 * SC) @(posedge clk);
    @(posedge clk);
    for (int n = 0; n < 24; n++)
      chk(32'(cnt[n]), on ? 32'(dv(n)) * SC : 32'h0);
  endtask : meas
  task automatic done(input string s);
    $display("test %0s finished", s);
  endtask : done
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    rst_to(rdc_pkg::OTYPE_LOW, 1'b0);
    for (int n = 0; n < 27; n++)
    begin
      xfer(1'b0, 32'(4 * n), 32'h0, q);
      chk(q, 32'h0);
    end
    xfer(1'b1, 32'h80, 32'h5, q);
    xfer(1'b0, 32'h80, 32'h0, q);
    chk(q, 32'h0);
    done("reset");
    xfer(1'b1, rdc_pkg::ADDR_RED_CUR, 32'hffff_ffff, q);
    xfer(1'b0, rdc_pkg::ADDR_RED_CUR, 32'h0, q);
    chk(q, 32'h1f);
    xfer(1'b1, rdc_pkg::ADDR_GRN_CUR, 32'h0a, q);
    xfer(1'b1, rdc_pkg::ADDR_BLU_CUR, 32'h15, q);
    repeat (3) @(posedge clk);
    chk(32'(sk.group_level), {17'h0, 5'h15, 5'h0a, 5'h1f});
    done("codes");
    load_duty();
    meas(1'b1);
    sn.uvlo <= 1'b1;
    repeat (8) @(posedge clk);
    meas(1'b0);
    sn <= '{supply_ok: 1'b1, overtemp: 1'b1, default: 1'b0};
    repeat (8) @(posedge clk);
    meas(1'b0);
    sn.overtemp <= 1'b0;
    repeat (300) @(posedge clk);
    meas(1'b1);
    done("duty");
    sn.ext_reset <= 1'b1;
    repeat (8) @(posedge clk);
    xfer(1'b1, rdc_pkg::ADDR_RED_CUR, 32'h5, q);
    xfer(1'b0, rdc_pkg::ADDR_RED_CUR, 32'h0, q);
    chk(q, 32'h0);
    sn.ext_reset <= 1'b0;
    repeat (8) @(posedge clk);
    xfer(1'b1, rdc_pkg::ADDR_BLU_CUR, 32'h7, q);
    sn.supply_ok <= 1'b0;
    repeat (8) @(posedge clk);
    sn.supply_ok <= 1'b1;
    repeat (8) @(posedge clk);
    xfer(1'b0, rdc_pkg::ADDR_BLU_CUR, 32'h0, q);
    chk(q, 32'h0);
    done("clear");
    for (int t = 0; t < 3; t++)
    begin
      rst_to(2'(t), 1'b0);
      chk(32'(sk.const_current), t == 0 ? 32'hff_ffff :
        t == 1 ? 32'h3f_3f3f : 32'h0);
    end
    load_duty();
    meas(1'b1);
    rst_to(rdc_pkg::OTYPE_LOW, 1'b1);
    xfer(1'b1, rdc_pkg::ADDR_RED_CUR, 32'h3, q);
    repeat (3) @(posedge clk);
    chk(32'(sk.group_level), 32'h7fff);
    xfer(1'b0, rdc_pkg::ADDR_STATUS, 32'h0, q);
    chk(q & 32'hffff_00ff, (32'h1 << rdc_pkg::ST_SUPPLY_OK)
      | (32'h1 << rdc_pkg::ST_ALL_REF) | (32'h1 << rdc_pkg::ST_CFG_DONE));
    done("modes");
    complete_run();
  end
endmodule : rgb_led_dimming_control_bench
`default_nettype wire
